// File: hdl/sysctl_pkg.sv
// Shared constants for the system-control glue logic.
// Assumes a single 100 MHz system clock and an active-high async reset.
package sysctl_pkg;

   // ======================================================================
   // Address space
   // ======================================================================
   localparam int unsigned ADDR_WIDTH     = 20;
   localparam int unsigned ROM_NIB_MSB    = 19;
   localparam int unsigned ROM_NIB_LSB    = 16;
   localparam logic [3:0]  ROM_NIB        = 4'hF;
   localparam logic [19:0] ROM_BASE       = 20'hF0000;
   localparam logic [19:0] ROM_LAST       = 20'hFFFFF;
   localparam logic [19:0] ADDR_RESET     = 20'h00000;

   // ======================================================================
   // Clock and synchronisers
   // ======================================================================
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned SYNC_STAGES    = 3;
   localparam logic [2:0]  SYNC_RESET     = 3'h7;

   // ======================================================================
   // Reset values of registered control state
   // ======================================================================
   localparam logic        READY_RESET    = 1'b1;
   localparam logic        TC_RESET       = 1'b0;
   localparam logic        DONE_RESET     = 1'b0;

endpackage : sysctl_pkg

// File: hdl/addr_latch.sv
// Address latch with tri-state style output enable.
// Assumes the latch strobe comes from logic on the same system clock.
module addr_latch #(
   parameter int unsigned WIDTH = sysctl_pkg::ADDR_WIDTH
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   input  wire logic             latch_strobe_i,
   input  wire logic             bus_grant_i,
   input  wire logic [WIDTH-1:0] addr_in_i,
   output logic      [WIDTH-1:0] addr_o,
   output logic                  addr_oe_o
);

   // ======================================================================
   // Capture
   // ======================================================================
   // latch on strobe
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         addr_o <= WIDTH'(sysctl_pkg::ADDR_RESET);
      end else if (latch_strobe_i) begin
         addr_o <= addr_in_i;
      end
   end

   // ======================================================================
   // Drive enable
   // ======================================================================
   // float on grant
   assign addr_oe_o = ~bus_grant_i;

   hold_addr_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !latch_strobe_i |=> $stable(addr_o))
      else $error("address changed without strobe");

   load_addr_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      latch_strobe_i |=> addr_o == $past(addr_in_i))
      else $error("address not loaded on strobe");

   float_addr_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      addr_oe_o != bus_grant_i)
      else $error("address driven during grant");

endmodule : addr_latch

// File: hdl/sysctl_glue.sv
// System-control glue between the processor bus and the system board:
// boot ROM select, board data buffer control, NMI gating, address latch,
// bus grant, wait stretching and DMA terminal count.
// Assumes bus strobes come from logic on clk_sys_i, except READY, which
// is a wired pin from the expansion bus and is synchronised here.
module sysctl_glue #(
   parameter int unsigned ADDR_W = sysctl_pkg::ADDR_WIDTH,
   parameter int unsigned STAGES = sysctl_pkg::SYNC_STAGES
) (
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   // Bus cycle qualifiers
   input  wire logic              mem_read_n_i,
   input  wire logic              io_read_n_i,
   input  wire logic              io_cycle_n_i,
   input  wire logic              memio_sel_n_i,
   input  wire logic              fdc_dack_n_i,
   input  wire logic              refresh_n_i,
   // Address for the ROM decode
   input  wire logic              addr_bit19_i,
   input  wire logic              addr_bit18_i,
   input  wire logic              addr_bit17_i,
   input  wire logic              addr_bit16_i,
   // Address latch
   input  wire logic              ale_i,
   input  wire logic [ADDR_W-1:0] cpu_addr_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   addr_oe_o,
   // Bus grant
   input  wire logic              dma_hold_i,
   output logic                   aen_o,
   output logic                   cmd_oe_o,
   // Interrupt gating
   input  wire logic              nmi_i,
   input  wire logic              nmi_mask_en_i,
   output logic                   nmi_gated_o,
   // Data buffers
   input  wire logic              cpu_read_n_i,
   input  wire logic              data_gate_n_i,
   output logic                   cpu_xcvr_dir_o,
   output logic                   cpu_xcvr_en_n_o,
   output logic                   rom_sel_n_o,
   output logic                   buf_enable_n_o,
   output logic                   buf_dir_o,
   // Wait stretch
   input  wire logic              ready_i,
   output logic                   cpu_ready_o,
   // DMA terminal count
   input  wire logic              dma_count_done_i,
   output logic                   dma_terminal_count_o
);

   // ======================================================================
   // Active-high views of the pins
   // ======================================================================
   logic mem_read;
   logic io_read;
   logic io_cycle;
   logic memio_sel;
   logic fdc_dack;
   logic refresh;
   logic rom_sel;

   assign mem_read  = ~mem_read_n_i;
   assign io_read   = ~io_read_n_i;
   assign io_cycle  = ~io_cycle_n_i;
   assign memio_sel = ~memio_sel_n_i;
   assign fdc_dack  = ~fdc_dack_n_i;
   assign refresh   = ~refresh_n_i;

   // ======================================================================
   // Decode functions
   // ======================================================================
   // Top 64K hit, used only by the ROM select decode
   function automatic logic rom_hit(input logic [3:0] nib);
      rom_hit = (nib == sysctl_pkg::ROM_NIB);
   endfunction : rom_hit

   // Read towards the processor, used only by the buffer direction decode
   function automatic logic toward_cpu(
      input logic mr, input logic ir, input logic ioc,
      input logic ms, input logic fd);
      logic mem_term;
      logic io_term;
      mem_term = mr & ~ioc & (~fd | ms | ir);
      io_term  = (ir & ioc) | (ir & fd & ~ms & ~mr);
      toward_cpu = mem_term | io_term;
   endfunction : toward_cpu

   // ======================================================================
   // ROM select
   // ======================================================================
   // ROM window decode
   assign rom_sel = mem_read & ~refresh
                  & rom_hit({addr_bit19_i, addr_bit18_i,
                             addr_bit17_i, addr_bit16_i});
   assign rom_sel_n_o = ~rom_sel;

   // ======================================================================
   // Board data buffer
   // ======================================================================
   // read direction, for memory and I/O reads
   assign buf_dir_o = ~toward_cpu(mem_read, io_read, io_cycle,
                                  memio_sel, fdc_dack);

   assign buf_enable_n_o = (~memio_sel & ~rom_sel & ~fdc_dack)
                         | (memio_sel & fdc_dack);

   // ======================================================================
   // Processor data transceiver
   // ======================================================================
   // direction and gate
   assign cpu_xcvr_dir_o  = cpu_read_n_i;
   assign cpu_xcvr_en_n_o = data_gate_n_i;

   // ======================================================================
   // NMI gating
   // ======================================================================
   // masked NMI
   assign nmi_gated_o = nmi_mask_en_i & nmi_i;

   // ======================================================================
   // Bus grant and address latch
   // ======================================================================
   // grant to masters
   assign aen_o    = dma_hold_i;
   assign cmd_oe_o = ~dma_hold_i;

   addr_latch #(
      .WIDTH          (ADDR_W)
   ) u_addr_latch (
      .clk_sys_i      (clk_sys_i),
      .reset_i        (reset_i),
      .latch_strobe_i (ale_i),
      .bus_grant_i    (dma_hold_i),
      .addr_in_i      (cpu_addr_i),
      .addr_o         (addr_o),
      .addr_oe_o      (addr_oe_o)
   );

   // ======================================================================
   // READY synchroniser and wait stretch
   // ======================================================================
   logic [STAGES-1:0] ready_sync;

   // Shift chain; first stage is read only by the second
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ready_sync <= STAGES'(sysctl_pkg::SYNC_RESET);
      end else begin
         ready_sync <= {ready_sync[STAGES-2:0], ready_i};
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cpu_ready_o <= sysctl_pkg::READY_RESET;
      end else if (ready_sync[STAGES-1] == ready_sync[STAGES-2]) begin
         cpu_ready_o <= ready_sync[STAGES-1];
      end
   end

   // ======================================================================
   // DMA terminal count
   // ======================================================================
   logic count_done_q;

   // Edge memory of the end-of-count level
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         count_done_q <= sysctl_pkg::DONE_RESET;
      end else begin
         count_done_q <= dma_count_done_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         dma_terminal_count_o <= sysctl_pkg::TC_RESET;
      end else begin
         dma_terminal_count_o <= dma_count_done_i & ~count_done_q;
      end
   end

   // ======================================================================
   // Checks
   // ======================================================================
   // refresh blocks ROM
   rom_refresh_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (refresh || !mem_read) |-> rom_sel_n_o)
      else $error("ROM selected outside a memory read");

   rom_window_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (mem_read && !refresh && addr_bit19_i && addr_bit18_i
       && addr_bit17_i && addr_bit16_i) |-> !rom_sel_n_o)
      else $error("ROM not selected in top 64K read");

   rom_low_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !(addr_bit19_i && addr_bit18_i && addr_bit17_i && addr_bit16_i)
      |-> rom_sel_n_o)
      else $error("ROM selected below the top 64K");

   dir_mem_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (mem_read && !io_cycle && !fdc_dack) |-> !buf_dir_o)
      else $error("buffer direction wrong in memory read");

   dir_io_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (io_read && io_cycle) |-> !buf_dir_o)
      else $error("buffer direction wrong in I/O read");

   dir_idle_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (!mem_read && !io_read) |-> buf_dir_o)
      else $error("buffer turned without a read");

   enb_clash_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (memio_sel && fdc_dack) |-> buf_enable_n_o)
      else $error("buffer enabled with select and ack");

   enb_rom_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (!rom_sel_n_o && !fdc_dack && !memio_sel) |-> !buf_enable_n_o)
      else $error("buffer off during ROM read");

   enb_sel_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (memio_sel && !fdc_dack) |-> !buf_enable_n_o)
      else $error("buffer off during selected cycle");

   nmi_mask_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !nmi_mask_en_i |-> !nmi_gated_o)
      else $error("NMI passed while masked");

   nmi_pass_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (nmi_mask_en_i && nmi_i) |-> nmi_gated_o)
      else $error("NMI lost while enabled");

   grant_cmd_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      aen_o |-> (!cmd_oe_o && !addr_oe_o))
      else $error("commands driven during grant");

   ready_low_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (!ready_i [*4]) |=> !cpu_ready_o)
      else $error("cycle not stretched by READY low");

   ready_high_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (ready_i [*4]) |=> cpu_ready_o)
      else $error("cycle still stretched after READY high");

   tc_pulse_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      dma_terminal_count_o |=> !dma_terminal_count_o)
      else $error("terminal count longer than one cycle");

   tc_rise_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      $rose(dma_count_done_i) |=> dma_terminal_count_o)
      else $error("terminal count missed");

   tc_cause_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      dma_terminal_count_o
      |-> ($past(dma_count_done_i) && !$past(dma_count_done_i, 2)))
      else $error("terminal count without end of count");

   xcvr_gate_a: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (cpu_xcvr_en_n_o == data_gate_n_i)
      && (cpu_xcvr_dir_o == cpu_read_n_i))
      else $error("transceiver not following gate or read");

endmodule : sysctl_glue

// File: tb/sysctl_peer.sv
// Far-side model: an expansion-bus peripheral that stretches cycles
// and the DMA controller that raises its end-of-count level.
// Assumes the bench calls one task at a time, on the system clock.
module sysctl_peer (
   input  wire logic clk_sys_i,
   output logic      ready_o,
   output logic      count_done_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // =====================================================================
   // Idle levels
   // =====================================================================
   // pull-up idles high
   initial begin
      ready_o      = 1'b1;
      count_done_o = 1'b0;
   end

   // =====================================================================
   // Peripheral wait and end of count
   // =====================================================================
   // hold wait low
   task automatic stall(input int cycles);
      @(posedge clk_sys_i);
      ready_o <= 1'b0;
      repeat (cycles) @(posedge clk_sys_i);
      ready_o <= 1'b1;
   endtask : stall

   task automatic count_end(input int cycles);
      @(posedge clk_sys_i);
      count_done_o <= 1'b1;
      repeat (cycles) @(posedge clk_sys_i);
      count_done_o <= 1'b0;
   endtask : count_end
endmodule : sysctl_peer

// File: tb/sysctl_glue_test.sv
// Self-checking bench for the system-control glue logic.
// Assumes a 100 MHz clock and the far-side model in sysctl_peer.
module sysctl_glue_test;
   timeunit 1ns;
   timeprecision 100ps;

   // =====================================================================
   // Signals
   // =====================================================================
   logic        clk_sys, reset, mem_read_n, io_read_n, io_cycle_n;
   logic        memio_sel_n, fdc_dack_n, refresh_n, ale, dma_hold;
   logic        a19, a18, a17, a16, nmi, nmi_mask_en, cpu_read_n;
   logic        data_gate_n, ready, count_done, addr_oe, aen, cmd_oe;
   logic        nmi_gated, xcvr_dir, xcvr_en_n, rom_sel_n, buf_en_n;
   logic        buf_dir, cpu_ready, tc;
   logic [19:0] cpu_addr, addr;
   int          n_fail, comparisons;

   sysctl_glue uut (.clk_sys_i(clk_sys), .reset_i(reset),
      .mem_read_n_i(mem_read_n), .io_read_n_i(io_read_n),
      .io_cycle_n_i(io_cycle_n), .memio_sel_n_i(memio_sel_n),
      .fdc_dack_n_i(fdc_dack_n), .refresh_n_i(refresh_n),
      .addr_bit19_i(a19), .addr_bit18_i(a18), .addr_bit17_i(a17),
      .addr_bit16_i(a16), .ale_i(ale), .cpu_addr_i(cpu_addr),
      .addr_o(addr), .addr_oe_o(addr_oe), .dma_hold_i(dma_hold),
      .aen_o(aen), .cmd_oe_o(cmd_oe), .nmi_i(nmi),
      .nmi_mask_en_i(nmi_mask_en), .nmi_gated_o(nmi_gated),
      .cpu_read_n_i(cpu_read_n), .data_gate_n_i(data_gate_n),
      .cpu_xcvr_dir_o(xcvr_dir), .cpu_xcvr_en_n_o(xcvr_en_n),
      .rom_sel_n_o(rom_sel_n), .buf_enable_n_o(buf_en_n),
      .buf_dir_o(buf_dir), .ready_i(ready), .cpu_ready_o(cpu_ready),
      .dma_count_done_i(count_done), .dma_terminal_count_o(tc));

   sysctl_peer peer (.clk_sys_i(clk_sys), .ready_o(ready),
      .count_done_o(count_done));

   // =====================================================================
   // Clock, compare and closing
   // =====================================================================
   // Free-running 10 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk1(input logic got, input logic exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %b", $time, m, got);
      end
   endtask : chk1

   task automatic chk20(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t address got %h", $time, got);
      end
   endtask : chk20

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // Cuts a hang short
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_fail++;
      test_done();
   end

   // =====================================================================
   // Scenarios
   // =====================================================================
   // Expected {rom_sel_n, buf_enable_n, buf_dir} for bits k:
   // 0 mem read, 1 io read, 2 io cycle, 3 select, 4 floppy ack,
   // 5 refresh, 9..6 address nibble; all active high here
   function automatic logic [2:0] decode_exp(input logic [9:0] k);
      logic rom, en_n, low;
      rom  = k[0] & ~k[5] & (&k[9:6]);
      en_n = (~k[3] & ~rom & ~k[4]) | (k[3] & k[4]);
      low  = (k[0] & ~k[2] & (~k[4] | k[3] | k[1])) | (k[1] & k[2])
             | (k[1] & k[4] & ~k[3] & ~k[0]);
      return {~rom, en_n, ~low};
   endfunction : decode_exp

   task automatic decode_sweep();
      logic [2:0] e;
      for (int k = 0; k < 1024; k++) begin
         @(posedge clk_sys);
         {a19, a18, a17, a16} <= k[9:6];
         refresh_n   <= ~k[5];
         fdc_dack_n  <= ~k[4];
         memio_sel_n <= ~k[3];
         io_cycle_n  <= ~k[2];
         io_read_n   <= ~k[1];
         mem_read_n  <= ~k[0];
         @(negedge clk_sys);
         e = decode_exp(k[9:0]);
         chk1(rom_sel_n, e[2], "rom select");
         chk1(buf_en_n, e[1], "buffer enable");
         chk1(buf_dir, e[0], "buffer direction");
      end
   endtask : decode_sweep

   task automatic gate_sweep();
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_sys);
         nmi         <= j[0];
         cpu_read_n  <= j[0];
         nmi_mask_en <= j[1];
         data_gate_n <= j[1];
         @(negedge clk_sys);
         chk1(nmi_gated, j[0] & j[1], "nmi gate");
         chk1(xcvr_dir, j[0], "xcvr dir");
         chk1(xcvr_en_n, j[1], "xcvr enable");
      end
   endtask : gate_sweep

   task automatic latch_grant();
      @(posedge clk_sys);
      ale      <= 1'b1;
      cpu_addr <= 20'hF0001;
      @(posedge clk_sys);
      cpu_addr <= 20'h0FFFE;
      @(negedge clk_sys);
      chk20(addr, 20'hF0001);
      @(posedge clk_sys);
      ale      <= 1'b0;
      cpu_addr <= 20'h5A5A5;
      repeat (2) @(negedge clk_sys);
      chk20(addr, 20'h0FFFE);
      @(posedge clk_sys);
      dma_hold <= 1'b1;
      @(negedge clk_sys);
      chk1(aen, 1'b1, "grant");
      chk1(addr_oe, 1'b0, "address float");
      chk1(cmd_oe, 1'b0, "command float");
      @(posedge clk_sys);
      dma_hold <= 1'b0;
      @(negedge clk_sys);
      chk1(addr_oe, 1'b1, "address drive");
      chk1(aen, 1'b0, "grant end");
      chk1(cmd_oe, 1'b1, "command drive");
   endtask : latch_grant

   task automatic wait_stretch();
      fork
         peer.stall(8);
         begin
            @(posedge clk_sys);
            repeat (5) @(negedge clk_sys);
            chk1(cpu_ready, 1'b0, "stretch");
         end
      join
      @(negedge clk_sys);
      chk1(cpu_ready, 1'b0, "stretch tail");
      repeat (4) @(negedge clk_sys);
      chk1(cpu_ready, 1'b1, "stretch end");
   endtask : wait_stretch

   // one pulse for a held level, then one after re-arming
   task automatic terminal_count();
      int first, pulses;
      for (int r = 0; r < 2; r++) begin
         first  = 0;
         pulses = 0;
         fork
            peer.count_end(5 - 4 * r);
            for (int i = 1; i <= 8; i++) begin
               @(negedge clk_sys);
               if (tc === 1'b1) begin
                  pulses++;
                  if (first == 0) first = i;
               end
            end
         join
         chk1(pulses == 1, 1'b1, "pulse count");
         chk1(first == 2, 1'b1, "pulse moment");
      end
   endtask : terminal_count

   // Main sequence
   initial begin
      n_fail      = 0;
      comparisons = 0;
      reset       <= 1'b1;
      {mem_read_n, io_read_n, io_cycle_n, memio_sel_n} <= 4'hF;
      {fdc_dack_n, refresh_n, cpu_read_n, data_gate_n} <= 4'hF;
      {a19, a18, a17, a16, ale, dma_hold} <= 6'h00;
      {nmi, nmi_mask_en} <= 2'h0;
      cpu_addr    <= 20'h00000;
      repeat (7) @(posedge clk_sys);
      @(negedge clk_sys);
      chk20(addr, sysctl_pkg::ADDR_RESET);
      chk1(cpu_ready, sysctl_pkg::READY_RESET, "ready reset");
      chk1(tc, sysctl_pkg::TC_RESET, "count reset");
      @(posedge clk_sys);
      reset <= 1'b0;
      decode_sweep();
      gate_sweep();
      latch_grant();
      wait_stretch();
      terminal_count();
      test_done();
   end
endmodule : sysctl_glue_test
